// ==== include/sfpi_pkg.sv ====
package sfpi_pkg;

   // clock of the system side
   localparam int SYS_CLK_HZ = 50_000_000;

   // widths
   localparam int BYTE_W = 8;
   localparam int LANE_N = 4;
   localparam int RX_W = 9;

   // lane-width codes
   localparam logic [1:0] LANES_1 = 2'h0;
   localparam logic [1:0] LANES_2 = 2'h1;
   localparam logic [1:0] LANES_4 = 2'h2;

   // instructions that switch the command mode
   localparam logic [7:0] CMD_ENTER_FOUR = 8'h35;
   localparam logic [7:0] CMD_EXIT_FOUR = 8'hF5;

   // status register layout and reset value
   localparam int SR_WD_BIT = 7;
   localparam int SR_QE_BIT = 6;
   localparam int SR_BP_LSB = 2;
   localparam logic [7:0] SR_RESET = 8'h00;

   // configuration word carried to the link side
   localparam int CFG_W = 4;
   localparam int CFG_TX_BIT = 3;
   localparam int CFG_QE_BIT = 2;
   localparam int CFG_LANES_LSB = 0;
   localparam logic [3:0] CFG_RESET = 4'h0;

   // bits in one byte on the link
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// ==== include/sfpi_stream_if.sv ====
`timescale 1ns/1ps
interface sfpi_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic valid;
   logic ready;

   modport src(output data, output valid, input ready);
   modport snk(input data, input valid, output ready);
endinterface

// ==== src/sfpi_fifo2.sv ====
`timescale 1ns/1ps
module sfpi_fifo2 #(
   parameter int W = 9,
   parameter int DEPTH = 2
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // streams
   sfpi_stream_if.snk in_if,
   sfpi_stream_if.src out_if
);

   // depth must be a power of two so the pointers wrap by themselves
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_if.ready = (count != FULL);
   assign out_if.valid = (count != '0);
   assign out_if.data = mem[rd_ptr];
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_if.data;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop)
         begin
            count <= count + 1'b1;
         end
         else if (pop && !push)
         begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

// ==== src/sfpi_word_cdc.sv ====
`timescale 1ns/1ps
module sfpi_word_cdc #(
   parameter int W = 8
)
(
   // clocks and reset
   input wire logic src_clk_i,
   input wire logic dst_clk_i,
   input wire logic rst_i,
   // source side
   sfpi_stream_if.snk in_if,
   // destination side
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_take_i
);

   logic [W-1:0] hold;
   logic req;
   logic ack_s1;
   logic ack_s2;
   logic req_s1;
   logic req_s2;
   logic ack;

   // one word in flight; hold stays put until the ack returns
   assign in_if.ready = (req == ack_s2);
   assign out_valid_o = (req_s2 != ack);
   assign out_data_o = hold;

   always_ff @(posedge src_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hold <= '0;
         req <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end
      else
      begin
         ack_s1 <= ack;
         ack_s2 <= ack_s1;
         if (in_if.valid && in_if.ready)
         begin
            hold <= in_if.data;
            req <= !req;
         end
      end
   end

   always_ff @(posedge dst_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         ack <= 1'b0;
      end
      else
      begin
         req_s1 <= req;
         req_s2 <= req_s1;
         if (out_take_i && out_valid_o)
         begin
            ack <= req_s2;
         end
      end
   end

endmodule

// ==== src/sfpi_flash_pins.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - select high: all pins floated, block reports low-power standby
// - select low: block selected, leaves standby, takes and returns data
// - no instruction taken until select has been high after power-up
// - bits on the lanes are ignored while select is high
// - single lane: master drives lane 0, captured on clock rise
// - single lane: device drives lane 1, updated on clock fall
// - dual and quad: lanes two-way, in on rise, out on fall
// - quad: write-protect pin is lane 2, pause pin is lane 3
// - write-disable set and protect pin low: status writes refused
// - write-disable clear: status writes accepted whatever the protect pin
// - quad enable set: protect pin loses protect function, is lane 2
// - quad enable set or quad lanes: pause pin is lane 3, otherwise a pause input
// - pause low while selected: output floated, shifting frozen, then resumes
// - 35h enters four-lane command mode, F5h leaves, reset restores serial
module sfpi_flash_pins
(
   // system side
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // link pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic [3:0] lane_i,
   output logic [3:0] lane_o,
   output logic [3:0] lane_oe_o,
   // control
   input wire logic [1:0] lane_mode_i,
   input wire logic tx_phase_i,
   input wire logic sr_wr_i,
   input wire logic [7:0] sr_wdata_i,
   // status
   output logic standby_o,
   output logic selected_o,
   output logic four_lane_command_mode_o,
   output logic [7:0] status_o,
   output logic sr_wr_rejected_o,
   output logic rx_overrun_o,
   // received bytes
   output logic [7:0] rx_data_o,
   output logic rx_first_o,
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   // bytes to return
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [3:0] lane_step(input logic [1:0] l);
      case (l)
         sfpi_pkg::LANES_2: lane_step = 4'h2;
         sfpi_pkg::LANES_4: lane_step = 4'h4;
         default: lane_step = 4'h1;
      endcase
   endfunction

   function automatic logic [3:0] lane_bits(input logic [7:0] w, input logic [1:0] l);
      case (l)
         sfpi_pkg::LANES_2: lane_bits = {2'h0, w[7:6]};
         sfpi_pkg::LANES_4: lane_bits = w[7:4];
         default: lane_bits = {2'h0, w[7], 1'b0};
      endcase
   endfunction

   function automatic logic [3:0] lane_mask(input logic [1:0] l);
      case (l)
         sfpi_pkg::LANES_2: lane_mask = 4'h3;
         sfpi_pkg::LANES_4: lane_mask = 4'hF;
         default: lane_mask = 4'h2;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // system side: synchronisers and reset toward the link

   logic cs_s1;
   logic cs_s2;
   logic wp_s1;
   logic wp_s2;
   logic link_rst;

   // select is sampled through reset, so a pin low since power-up never arms
   always_ff @(posedge sys_clk_i)
   begin
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         wp_s1 <= 1'b1;
         wp_s2 <= 1'b1;
      end
      else
      begin
         wp_s1 <= lane_i[2];
         wp_s2 <= wp_s1;
      end
   end

   // the link clock may stand still, so its handshake state is cleared
   // from a registered copy of the system reset
   always_ff @(posedge sys_clk_i)
   begin
      link_rst <= !rst_n_i;
   end

   assign standby_o = cs_s2;
   assign selected_o = !cs_s2;

   ////////////////////////////////////////////////////////////////////////////
   // system side: arming, command mode, status register

   logic armed;
   logic four_lane;
   logic [7:0] sr;
   logic sr_rej;
   logic [sfpi_pkg::CFG_W-1:0] cfg_q;
   logic [1:0] lanes_eff;
   logic wp_active;
   logic [sfpi_pkg::RX_W-1:0] rx_hold;
   logic rt_s1;
   logic rt_s2;
   logic rt_s3;
   logic rx_new;

   // frames that began before select was ever seen high are dropped
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         armed <= 1'b0;
      end
      else if (cs_s2)
      begin
         armed <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         four_lane <= 1'b0;
      end
      else if (rx_new && armed && rx_hold[8])
      begin
         if (rx_hold[7:0] == sfpi_pkg::CMD_ENTER_FOUR)
         begin
            four_lane <= 1'b1;
         end
         else if (rx_hold[7:0] == sfpi_pkg::CMD_EXIT_FOUR)
         begin
            four_lane <= 1'b0;
         end
      end
   end

   // quad enable turns the protect pin into a plain data lane
   assign wp_active = !sr[sfpi_pkg::SR_QE_BIT] && !wp_s2;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         sr <= sfpi_pkg::SR_RESET;
         sr_rej <= 1'b0;
      end
      else
      begin
         sr_rej <= 1'b0;
         if (sr_wr_i)
         begin
            if (sr[sfpi_pkg::SR_WD_BIT] && wp_active)
            begin
               sr_rej <= 1'b1;
            end
            else
            begin
               sr <= sr_wdata_i;
            end
         end
      end
   end

   assign lanes_eff = four_lane ? sfpi_pkg::LANES_4 : lane_mode_i;

   // quasi-static settings; change them only while deselected
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg_q <= sfpi_pkg::CFG_RESET;
      end
      else
      begin
         cfg_q <= {tx_phase_i, sr[sfpi_pkg::SR_QE_BIT], lanes_eff};
      end
   end

   assign four_lane_command_mode_o = four_lane;
   assign status_o = sr;
   assign sr_wr_rejected_o = sr_rej;

   ////////////////////////////////////////////////////////////////////////////
   // system side: received bytes into the two-entry buffer

   sfpi_stream_if #(.W(sfpi_pkg::RX_W)) rx_in_if ();
   sfpi_stream_if #(.W(sfpi_pkg::RX_W)) rx_out_if ();

   logic rx_pend;
   logic [sfpi_pkg::RX_W-1:0] rx_word;
   logic rx_ovr;
   logic rx_tgl;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rt_s1 <= 1'b0;
         rt_s2 <= 1'b0;
         rt_s3 <= 1'b0;
      end
      else
      begin
         rt_s1 <= rx_tgl;
         rt_s2 <= rt_s1;
         rt_s3 <= rt_s2;
      end
   end

   assign rx_new = rt_s2 ^ rt_s3;

   // a full buffer stalls the pending byte; only a fourth byte is lost
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_pend <= 1'b0;
         rx_word <= '0;
         rx_ovr <= 1'b0;
      end
      else
      begin
         rx_ovr <= rx_new && armed && rx_pend && !rx_in_if.ready;
         if (rx_new && armed && (!rx_pend || rx_in_if.ready))
         begin
            rx_word <= rx_hold;
            rx_pend <= 1'b1;
         end
         else if (rx_in_if.ready)
         begin
            rx_pend <= 1'b0;
         end
      end
   end

   assign rx_in_if.valid = rx_pend;
   assign rx_in_if.data = rx_word;
   assign rx_out_if.ready = rx_ready_i;
   assign rx_valid_o = rx_out_if.valid;
   assign rx_data_o = rx_out_if.data[7:0];
   assign rx_first_o = rx_out_if.data[8];
   assign rx_overrun_o = rx_ovr;

   sfpi_fifo2 #(.W(sfpi_pkg::RX_W), .DEPTH(2)) u_rx_buf (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .in_if(rx_in_if),
      .out_if(rx_out_if)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bytes to return, crossing to the falling-edge link logic

   sfpi_stream_if #(.W(sfpi_pkg::BYTE_W)) tx_if ();

   logic sck_n;
   logic [7:0] tx_word;
   logic tx_word_valid;
   logic tx_take;

   assign sck_n = !sck_i;
   assign tx_if.data = tx_data_i;
   assign tx_if.valid = tx_valid_i;
   assign tx_ready_o = tx_if.ready;

   sfpi_word_cdc #(.W(sfpi_pkg::BYTE_W)) u_tx_cdc (
      .src_clk_i(sys_clk_i),
      .dst_clk_i(sck_n),
      .rst_i(link_rst),
      .in_if(tx_if),
      .out_data_o(tx_word),
      .out_valid_o(tx_word_valid),
      .out_take_i(tx_take)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link side: settings and pause

   logic [sfpi_pkg::CFG_W-1:0] cfg_l1;
   logic [sfpi_pkg::CFG_W-1:0] cfg_l;
   logic [1:0] lanes_l;
   logic [3:0] step;
   logic hold_now;

   always_ff @(posedge sck_i or posedge link_rst)
   begin
      if (link_rst)
      begin
         cfg_l1 <= sfpi_pkg::CFG_RESET;
         cfg_l <= sfpi_pkg::CFG_RESET;
      end
      else
      begin
         cfg_l1 <= cfg_q;
         cfg_l <= cfg_l1;
      end
   end

   assign lanes_l = cfg_l[sfpi_pkg::CFG_LANES_LSB +: 2];
   assign step = lane_step(lanes_l);

   // in quad use the pause pin is a data lane
   assign hold_now = !cfg_l[sfpi_pkg::CFG_QE_BIT] && (lanes_l != sfpi_pkg::LANES_4)
                     && !lane_i[3] && !cs_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // link side: capture on the rising edge

   logic [7:0] rx_sh;
   logic [7:0] rx_next;
   logic [3:0] rx_cnt;
   logic [3:0] next_rx_cnt;
   logic rx_first;
   logic rx_shift;
   logic byte_done;

   always_comb
   begin
      case (lanes_l)
         sfpi_pkg::LANES_2: rx_next = {rx_sh[5:0], lane_i[1:0]};
         sfpi_pkg::LANES_4: rx_next = {rx_sh[3:0], lane_i[3:0]};
         default: rx_next = {rx_sh[6:0], lane_i[0]};
      endcase
   end

   assign rx_shift = !hold_now && !cfg_l[sfpi_pkg::CFG_TX_BIT];
   assign next_rx_cnt = rx_cnt + step;
   assign byte_done = rx_shift && (next_rx_cnt == sfpi_pkg::BITS_PER_BYTE);

   // select high holds the frame state cleared, so bits are not taken
   always_ff @(posedge sck_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         rx_sh <= 8'h00;
         rx_cnt <= 4'h0;
         rx_first <= 1'b1;
      end
      else if (rx_shift)
      begin
         rx_sh <= rx_next;
         rx_cnt <= byte_done ? 4'h0 : next_rx_cnt;
         if (byte_done)
         begin
            rx_first <= 1'b0;
         end
      end
   end

   // held for at least two link clocks, far longer than the sync delay
   always_ff @(posedge sck_i or posedge link_rst)
   begin
      if (link_rst)
      begin
         rx_hold <= '0;
         rx_tgl <= 1'b0;
      end
      else if (byte_done && !cs_n_i)
      begin
         rx_hold <= {rx_first, rx_next};
         rx_tgl <= !rx_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link side: drive on the falling edge

   logic [7:0] tx_sh;
   logic [3:0] tx_left;
   logic [3:0] out_q;
   logic drive_q;

   assign tx_take = !cs_n_i && cfg_l[sfpi_pkg::CFG_TX_BIT] && !hold_now
                    && (tx_left == 4'h0) && tx_word_valid;

   always_ff @(negedge sck_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         tx_sh <= 8'h00;
         tx_left <= 4'h0;
         out_q <= 4'h0;
         drive_q <= 1'b0;
      end
      else if (!hold_now)
      begin
         if (tx_left != 4'h0)
         begin
            out_q <= lane_bits(tx_sh, lanes_l);
            tx_sh <= tx_sh << step;
            tx_left <= tx_left - step;
            drive_q <= 1'b1;
         end
         else if (tx_take)
         begin
            out_q <= lane_bits(tx_word, lanes_l);
            tx_sh <= tx_word << step;
            tx_left <= sfpi_pkg::BITS_PER_BYTE - step;
            drive_q <= 1'b1;
         end
         else
         begin
            drive_q <= 1'b0;
         end
      end
   end

   assign lane_o = out_q;
   assign lane_oe_o = (drive_q && cfg_l[sfpi_pkg::CFG_TX_BIT] && !cs_n_i && !hold_now)
                      ? lane_mask(lanes_l) : 4'h0;

endmodule

// ==== sim/sfpi_flash_pins_chk.sv ====
`timescale 1ns/1ps
module sfpi_flash_pins_chk
(
   // clocks and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic sck_i,
   // link pins
   input wire logic cs_n_i,
   input wire logic [3:0] lane_i,
   input wire logic [3:0] lane_o,
   input wire logic [3:0] lane_oe_o,
   // control and status
   input wire logic [1:0] lane_mode_i,
   input wire logic sr_wr_i,
   input wire logic [7:0] sr_wdata_i,
   input wire logic [7:0] status_o,
   input wire logic sr_wr_rejected_o,
   input wire logic standby_o,
   input wire logic selected_o,
   input wire logic four_lane_command_mode_o,
   // streams
   input wire logic rx_valid_o,
   input wire logic rx_ready_i,
   input wire logic [7:0] rx_data_o,
   input wire logic tx_valid_i,
   input wire logic tx_ready_o
);
////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // protect pin history: a level still in its synchroniser is not judged
   logic [2:0] wp_h;
   always_ff @(posedge sys_clk_i)
      wp_h <= {wp_h[1:0], lane_i[2]};
   AST_DESEL_FLOAT: assert property (
      cs_n_i |-> lane_oe_o == 4'h0) else $error("lanes driven while deselected");
   AST_STANDBY: assert property (
      cs_n_i [*5] |-> standby_o && !selected_o) else $error("no standby while deselected");
   AST_SELECTED: assert property (
      !cs_n_i [*5] |-> selected_o && !standby_o) else $error("not selected");
   AST_SR_OPEN: assert property (
      sr_wr_i && !status_o[7] |=> status_o == $past(sr_wdata_i) && !sr_wr_rejected_o)
      else $error("open status write lost");
   AST_SR_QE: assert property (
      sr_wr_i && status_o[6] |=> status_o == $past(sr_wdata_i))
      else $error("write refused with quad enable set");
   AST_SR_LOCK: assert property (
      sr_wr_i && status_o[7:6] == 2'h2 && !lane_i[2] && wp_h == 3'h0
      |=> sr_wr_rejected_o && $stable(status_o)) else $error("locked write taken");
   AST_SR_WP_HI: assert property (
      sr_wr_i && lane_i[2] && wp_h == 3'h7 |=> status_o == $past(sr_wdata_i))
      else $error("write refused with protect pin high");
   AST_PAUSE: assert property (
      !cs_n_i && !lane_i[3] && !status_o[6] && lane_mode_i != sfpi_pkg::LANES_4
      && !four_lane_command_mode_o |-> lane_oe_o == 4'h0) else $error("driven in pause");
   AST_OUT_FALL: assert property (
      $changed(lane_o) |-> !sck_i) else $error("output moved outside clock low");
   AST_TX_ONE: assert property (
      tx_valid_i && tx_ready_o |=> !tx_ready_o) else $error("second byte taken in flight");
   AST_RX_HOLD: assert property (
      rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("received byte dropped under stall");
   COV_REFUSED: cover property (sr_wr_rejected_o);
   COV_FOUR: cover property ($rose(four_lane_command_mode_o));
   COV_RX_TAKE: cover property (rx_valid_o && rx_ready_i);
endmodule

bind sfpi_flash_pins sfpi_flash_pins_chk chk (.sys_clk_i, .rst_n_i, .sck_i, .cs_n_i, .lane_i,
   .lane_o, .lane_oe_o, .lane_mode_i, .sr_wr_i, .sr_wdata_i, .status_o, .sr_wr_rejected_o,
   .standby_o, .selected_o, .four_lane_command_mode_o, .rx_valid_o, .rx_ready_i, .rx_data_o,
   .tx_valid_i, .tx_ready_o);

// ==== sim/sfpi_master_model.sv ====
`timescale 1ns/1ps
module sfpi_master_model
(
   // link pins
   output logic sck_o,
   output logic cs_n_o,
   output logic [3:0] lane_w_o,
   input wire logic [3:0] lane_o_i,
   input wire logic [3:0] lane_oe_i
);
////////////////////////////////////////////////////////////////////////////////
   logic [3:0] drv;
   logic en;
   logic wp;
   logic pause_n;
   int w;
   // released lanes 0 and 1 (and 2 and 3 at width four) toggle with the clock so a stale bit never passes for data
   always_comb
      for (int k = 0; k < 4; k++)
         if (lane_oe_i[k])
            lane_w_o[k] = lane_o_i[k];
         else if (k < w && en)
            lane_w_o[k] = drv[k];
         else if (k >= 2 && w < 4)
            lane_w_o[k] = (k == 2) ? wp : pause_n;
         else
            lane_w_o[k] = sck_o ^ k[0];
   initial
   begin
      sck_o = 1'b0;
      cs_n_o = 1'b0;
      drv = 4'h0;
      en = 1'b0;
      wp = 1'b1;
      pause_n = 1'b1;
      w = 1;
   end
   task automatic select();
      cs_n_o = 1'b0;
      #80;
   endtask
   // clock stands low between frames
   task automatic deselect();
      #80 cs_n_o = 1'b1;
      #400;
   endtask
   // data is set while the clock is low, taken by the device on the rise
   task automatic send(input logic [7:0] b, input int wd);
      w = wd;
      en = 1'b1;
      for (int i = 0; i < 8 / wd; i++)
      begin
         drv = 4'(b >> (8 - wd * (i + 1)));
         #80 sck_o = 1'b1;
         #80 sck_o = 1'b0;
      end
      en = 1'b0;
   endtask
   // lanes released; bits sampled on the rise once the device drives
   task automatic recv(output logic [7:0] b, input int wd);
      int n;
      n = 0;
      w = wd;
      b = 8'h00;
      for (int t = 0; t < 24 && n < 8 / wd; t++)
      begin
         #80 sck_o = 1'b1;
         if (|lane_oe_i)
         begin
            b = (b << wd) | ((wd == 1) ? 8'(lane_w_o[1]) : 8'(lane_w_o & 4'((1 << wd) - 1)));
            n++;
         end
         #80 sck_o = 1'b0;
      end
   endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sck_i;
   logic cs_n_i;
   logic [3:0] lane_i;
   logic [3:0] lane_o;
   logic [3:0] lane_oe_o;
   logic [1:0] lane_mode_i = 2'h0;
   logic tx_phase_i = 1'b0;
   logic sr_wr_i = 1'b0;
   logic [7:0] sr_wdata_i = 8'h00;
   logic standby_o;
   logic selected_o;
   logic four_lane_command_mode_o;
   logic [7:0] status_o;
   logic sr_wr_rejected_o;
   logic rx_overrun_o;
   logic [7:0] rx_data_o;
   logic rx_first_o;
   logic rx_valid_o;
   logic rx_ready_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic tx_valid_i = 1'b0;
   logic tx_ready_o;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int wd;
   logic [31:0] seed = 32'h0000_005a;
   logic ovr = 1'b0;
   logic [7:0] bq [4];
   logic [7:0] got [2];
   logic [7:0] r;
   logic [1:0] modes [3] = '{sfpi_pkg::LANES_1, sfpi_pkg::LANES_2, sfpi_pkg::LANES_4};
////////////////////////////////////////////////////////////////////////////////
   sfpi_flash_pins dut (.sys_clk_i, .rst_n_i, .sck_i, .cs_n_i, .lane_i, .lane_o, .lane_oe_o,
      .lane_mode_i, .tx_phase_i, .sr_wr_i, .sr_wdata_i, .standby_o, .selected_o,
      .four_lane_command_mode_o, .status_o, .sr_wr_rejected_o, .rx_overrun_o, .rx_data_o,
      .rx_first_o, .rx_valid_o, .rx_ready_i, .tx_data_i, .tx_valid_i, .tx_ready_o);
   sfpi_master_model m (.sck_o(sck_i), .cs_n_o(cs_n_i), .lane_w_o(lane_i), .lane_o_i(lane_o),
      .lane_oe_i(lane_oe_o));
   always #10 sys_clk_i = ~sys_clk_i;
   // overrun is a one-cycle pulse, so it is kept until looked at
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (rx_overrun_o === 1'b1)
         ovr <= 1'b1;
      if (cyc == 30000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic locked(input logic [7:0] cur, input logic wp);
      return cur[7] && !cur[6] && !wp;
   endfunction
   task automatic step();
      @(posedge sys_clk_i);
      #2;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic pop(input logic [7:0] exp, input logic first);
      for (int t = 0; t < 100 && rx_valid_o !== 1'b1; t++)
         step();
      check("rx byte", exp, rx_data_o);
      check("rx first", {7'h0, first}, {7'h0, rx_first_o});
      rx_ready_i = 1'b1;
      step();
      rx_ready_i = 1'b0;
      step();
   endtask
   // valid is left high so two offers never toggle it in one time step
   task automatic offer(input logic [7:0] b);
      tx_data_i = b;
      tx_valid_i = 1'b1;
      for (int t = 0; t < 300 && tx_ready_o !== 1'b1; t++)
         step();
      step();
   endtask
   task automatic sr_test(input logic [7:0] d, input logic wp);
      logic lk;
      logic [7:0] exp;
      m.wp = wp;
      repeat (4) step();
      lk = locked(status_o, wp);
      exp = lk ? status_o : d;
      sr_wdata_i = d;
      sr_wr_i = 1'b1;
      step();
      sr_wr_i = 1'b0;
      check("status", exp, status_o);
      check("refused", {7'h0, lk}, {7'h0, sr_wr_rejected_o});
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) step();
      rst_n_i = 1'b1;
      check("status reset", sfpi_pkg::SR_RESET, status_o);
      // frame open since power-up, then bits while deselected: both dropped
      m.send(8'h3c, 1);
      m.deselect();
      m.send(8'hc3, 1);
      for (int i = 0; i < 3; i++)
      begin
         wd = 1 << i;
         tx_phase_i = 1'b0;
         lane_mode_i = modes[i];
         // idle pulses while deselected carry new settings to the link side
         m.send(8'h00, 4);
         for (int j = 0; j < 4; j++)
            bq[j] = rnd();
         ovr = 1'b0;
         m.select();
         m.send(bq[0], wd);
         if (i < 2)
         begin
            m.pause_n = 1'b0;
            m.send(rnd(), wd);
            m.pause_n = 1'b1;
         end
         for (int j = 1; j < 4; j++)
            m.send(bq[j], wd);
         m.deselect();
         check("overrun", 8'h01, {7'h0, ovr});
         check("standby", 8'h01, {7'h0, standby_o});
         for (int j = 0; j < 3; j++)
            pop(bq[j], j == 0);
         tx_phase_i = 1'b1;
         m.send(8'h00, 4);
         fork
            begin
               offer(bq[0]);
               offer(bq[1]);
               tx_valid_i = 1'b0;
            end
            begin
               m.select();
               m.recv(got[0], wd);
               m.recv(got[1], wd);
               m.deselect();
            end
         join
         for (int j = 0; j < 2; j++)
            check("tx byte", bq[j], got[j]);
         $display("width %0d test done", wd);
      end
      tx_phase_i = 1'b0;
      lane_mode_i = sfpi_pkg::LANES_1;
      m.send(8'h00, 4);
      m.select();
      m.send(sfpi_pkg::CMD_ENTER_FOUR, 1);
      m.deselect();
      pop(sfpi_pkg::CMD_ENTER_FOUR, 1'b1);
      check("four lane", 8'h01, {7'h0, four_lane_command_mode_o});
      m.send(8'h00, 4);
      m.select();
      m.send(sfpi_pkg::CMD_EXIT_FOUR, 4);
      m.deselect();
      pop(sfpi_pkg::CMD_EXIT_FOUR, 1'b1);
      check("four lane", 8'h00, {7'h0, four_lane_command_mode_o});
      $display("mode test done");
      m.w = 1;
      sr_test(8'h80, 1'b1);
      sr_test(rnd(), 1'b0);
      sr_test(8'hc0, 1'b1);
      sr_test(rnd(), 1'b0);
      for (int j = 0; j < 12; j++)
      begin
         r = rnd();
         sr_test(rnd(), r[0]);
      end
      $display("status test done");
      end_of_test();
   end
endmodule
